// ==== bench/spfs_seq_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Port checks, one clock domain
module spfs_seq_sva #(
  parameter int unsigned WARMUP_CYCLES = 8,
  parameter int unsigned POLL_CYCLES   = 32
) (
  input wire logic                   ref_clk,
  input wire logic                   rst,
  input wire spfs_pkg::spfs_supply_t supply_in,
  input wire logic                   stop_req,
  input wire logic                   wake_irq,
  input wire logic                   pf_irq_prio_high,
  input wire logic                   pf_flag_clr,
  input wire spfs_pkg::spfs_power_t  power,
  input wire logic                   core_reset,
  input wire logic                   core_clk_en,
  input wire logic                   pf_flag,
  input wire logic                   vector_pf,
  input wire logic                   resume_valid,
  input wire logic [15:0]            resume_addr
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Stopped: retained, monitor and supplies off, not in reset
  wire logic stop_q;
  assign stop_q = !core_reset && !power.regulator_en && !power.monitor_en && power.sram_retain;
  a_stop_power_off: assert property (stop_req && core_clk_en && !core_reset
    && supply_in.above_power_on |=> power == 4'h1) else $error("stop entry left a supply on");
  a_drop_ignored: assert property (stop_q && !wake_irq && supply_in.above_power_on
    |=> stop_q && !$rose(pf_flag)) else $error("stop left without wake");
  a_wake_monitor: assert property (stop_q && wake_irq && supply_in.above_power_on
    |=> power.monitor_en) else $error("wake did not start monitor");
  a_flag_after_sense: assert property ($rose(pf_flag) |-> $past(power.monitor_en)
    && power.sram_retain) else $error("flag set without monitor");
  a_warmup_gate: assert property ($rose(core_clk_en) |-> $past(power.osc_en, 6)
    && power.regulator_en) else $error("clock before warm-up");
  a_vector_choice: assert property (vector_pf |-> pf_flag && $past(pf_irq_prio_high))
    else $error("wrong vector choice");
  a_reset_power_off: assert property ($rose(core_reset) |-> !power.regulator_en
    && !power.osc_en) else $error("reset with supplies on");
  a_poll_pulse: assert property (
    (core_reset && power.monitor_en && !power.regulator_en) [*4]
    |=> !power.monitor_en || power.regulator_en) else $error("poll pulse too long");
  a_below_por: assert property (!supply_in.above_power_on [*6] |-> core_reset
    && !core_clk_en && power == 4'h0) else $error("brown-out not held");
  a_resume_addr: assert property (resume_valid |-> resume_addr == 16'h8000
    && power.osc_en) else $error("bad resume");
  c_vector: cover property (vector_pf);
  c_resume: cover property (resume_valid);
  c_flag: cover property ($rose(pf_flag));
  c_poll: cover property (core_reset && $rose(power.monitor_en));
endmodule : spfs_seq_sva
bind spfs_sequencer spfs_seq_sva #(.WARMUP_CYCLES(WARMUP_CYCLES), .POLL_CYCLES(POLL_CYCLES))
  u_sva (.ref_clk, .rst, .supply_in, .stop_req, .wake_irq, .pf_irq_prio_high, .pf_flag_clr,
  .power, .core_reset, .core_clk_en, .pf_flag, .vector_pf, .resume_valid, .resume_addr);
`default_nettype wire

// ==== bench/test_stop_mode_power_fail_sequencer.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Bench
module test_stop_mode_power_fail_sequencer;
  typedef struct packed {
    logic [2:0] sup;
    logic       prio;
    logic       flag;
    logic       vec;
    logic       hold;
  } spfs_row_t;
  logic                   ref_clk = 1'h0;
  logic                   rst = 1'h1;
  spfs_pkg::spfs_supply_t supply_in = 3'h7;
  logic                   stop_req = 1'h0;
  logic                   wake_irq = 1'h0;
  logic                   prio = 1'h0;
  logic                   clr = 1'h0;
  spfs_pkg::spfs_power_t  power;
  logic                   core_reset, core_clk_en, pf_flag, vector_pf, resume_valid;
  logic [15:0]            resume_addr;
  logic                   vs, rs;
  int                     mismatches = 0;
  int                     check_count = 0;
  int                     cycles = 0;
  // Full supply, warning band with both priorities, then the reset band
  spfs_row_t rows [4] = '{'{3'h7, 1'h1, 1'h0, 1'h0, 1'h0}, '{3'h3, 1'h1, 1'h1, 1'h1, 1'h0},
                          '{3'h3, 1'h0, 1'h1, 1'h0, 1'h0}, '{3'h1, 1'h1, 1'h0, 1'h0, 1'h1}};
  spfs_sequencer #(.WARMUP_CYCLES(8), .POLL_CYCLES(32)) dut_u (.ref_clk(ref_clk), .rst(rst),
    .supply_in(supply_in), .stop_req(stop_req), .wake_irq(wake_irq), .pf_irq_prio_high(prio),
    .pf_flag_clr(clr), .power(power), .core_reset(core_reset), .core_clk_en(core_clk_en),
    .pf_flag(pf_flag), .vector_pf(vector_pf), .resume_valid(resume_valid),
    .resume_addr(resume_addr));
  always #2 ref_clk = ~ref_clk;
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  // Pulses are gathered on every step so none slips between checks
  task automatic step(input int n);
    repeat (n) begin
      @(negedge ref_clk);
      vs |= vector_pf;
      rs |= resume_valid;
    end
  endtask : step
  task automatic run_until(input logic hold);
    while (core_clk_en !== 1'h1 && !(hold && core_reset === 1'h1)) step(1);
    step(2);
  endtask : run_until
  task automatic tally_and_finish;
    if (mismatches == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish
  // Hang guard, far above the expected few hundred cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  initial begin
    vs = 1'h0;
    rs = 1'h0;
    step(2);
    chk("reset_power", {core_reset, core_clk_en, power}, 6'h20);
    rst = 1'h0;
    run_until(1'h0);
    chk("boot_resume", rs, 1'h1);
    foreach (rows[i]) begin
      prio = rows[i].prio;
      clr = 1'h1;
      step(1);
      clr = 1'h0;
      stop_req = 1'h1;
      step(1);
      stop_req = 1'h0;
      step(2);
      chk("power_stop", power, 4'h1);
      supply_in = rows[i].sup;
      step(6);
      chk("power_drop", {pf_flag, power}, 5'h01);
      vs = 1'h0;
      rs = 1'h0;
      wake_irq = 1'h1;
      step(1);
      wake_irq = 1'h0;
      chk("monitor_wake", power.monitor_en, 1'h1);
      run_until(rows[i].hold);
      chk("flag", pf_flag, rows[i].flag);
      chk("vector", vs, rows[i].vec);
      chk("core_reset", core_reset, rows[i].hold);
      if (rows[i].hold) begin
        chk("pfrst_power", {power.regulator_en, power.osc_en, power.sram_retain}, 3'h1);
        supply_in = 3'h7;
        run_until(1'h0);
        chk("resume", {rs, resume_addr}, 17'h18000);
      end
      chk("power_run", {power.regulator_en, power.osc_en, core_clk_en}, 3'h7);
      supply_in = 3'h7;
      step(4);
    end
    supply_in = 3'h0;
    step(8);
    chk("brownout", {core_reset, core_clk_en, pf_flag, power}, 7'h40);
    supply_in = 3'h7;
    run_until(1'h0);
    rst = 1'h1;
    step(2);
    chk("midrun_reset", {core_clk_en, power}, 5'h00);
    rst = 1'h0;
    run_until(1'h0);
    chk("rerun", core_clk_en, 1'h1);
    tally_and_finish();
  end
endmodule : test_stop_mode_power_fail_sequencer
`default_nettype wire

// ==== rtl/spfs_pkg.sv ====
`default_nettype none
package spfs_pkg;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int unsigned CLK_PERIOD_PS        = 4000;
  localparam int unsigned WARMUP_TIME_US       = 100;
  localparam int unsigned WARMUP_CYCLES        = (WARMUP_TIME_US * 1000000 + CLK_PERIOD_PS - 1)
                                                 / CLK_PERIOD_PS;
  localparam int unsigned POLL_PERIOD_US       = 1000;
  localparam int unsigned POLL_CYCLES          = (POLL_PERIOD_US * 1000000) / CLK_PERIOD_PS;
  localparam int unsigned POLL_ON_CYCLES       = 4;
  localparam int unsigned SETTLE_CYCLES        = 2;
  localparam int unsigned CNT_W                = 20;
  localparam logic [15:0] RESUME_ADDR          = 16'h8000;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [6:0] {
    ST_RUN    = 7'h01,
    ST_STOP   = 7'h02,
    ST_SENSE  = 7'h04,
    ST_WARMUP = 7'h08,
    ST_PFRST  = 7'h10,
    ST_RECOV  = 7'h20,
    ST_POR    = 7'h40
  } spfs_state_t;

  typedef struct packed {
    logic above_warning;
    logic above_reset;
    logic above_power_on;
  } spfs_supply_t;

  typedef struct packed {
    logic monitor_en;
    logic regulator_en;
    logic osc_en;
    logic sram_retain;
  } spfs_power_t;

endpackage : spfs_pkg
`default_nettype wire

// ==== rtl/spfs_sequencer.sv ====
// Functional notes
// - Stop with monitor off: monitor, regulator, oscillator off; SRAM retained.
// - Supply drop while stopped that stays above the power-on threshold is ignored: no flag, no wake.
// - Enabled interrupt in stop starts exit and turns monitor on.
// - Supply between reset and warning thresholds at wake sets power-fail flag.
// - Normal wake re-enables regulator and oscillator; core stalled during warm-up.
// - After exit with flag set, core takes higher priority of the two sources.
// - Supply between power-on and reset thresholds at wake holds reset, power off.
// - During power-fail reset the monitor runs periodically, SRAM retained except when entered from ST_POR.
// - Below power-on threshold everything is reset and off.
// - Recovery above reset threshold: warm-up, then resume from 8000h.
`timescale 1ns/1ps
`default_nettype none
module spfs_sequencer #(
  parameter int unsigned WARMUP_CYCLES = spfs_pkg::WARMUP_CYCLES,
  parameter int unsigned POLL_CYCLES   = spfs_pkg::POLL_CYCLES
) (
  input  wire logic                  ref_clk,
  input  wire logic                  rst,
  input  wire spfs_pkg::spfs_supply_t supply_in,
  input  wire logic                  stop_req,
  input  wire logic                  wake_irq,
  input  wire logic                  pf_irq_prio_high,
  input  wire logic                  pf_flag_clr,
  output spfs_pkg::spfs_power_t      power,
  output logic                       core_reset,
  output logic                       core_clk_en,
  output logic                       pf_flag,
  output logic                       vector_pf,
  output logic                       resume_valid,
  output logic [15:0]                resume_addr
);
  // ==========================================================================
  // Input synchronisation
  // ==========================================================================
  spfs_pkg::spfs_supply_t sup;
  logic [2:0]             sup_raw;

  // Comparator outputs are asynchronous to ref_clk, so two flops first
  spfs_sync #(.W(3)) u_sync (
    .ref_clk (ref_clk),
    .rst     (rst),
    .d       (supply_in),
    .q       (sup_raw)
  );
  assign sup = spfs_pkg::spfs_supply_t'(sup_raw);

  // ==========================================================================
  // Sequencer state
  // ==========================================================================
  spfs_pkg::spfs_state_t  state_ff,   nxt_state;
  spfs_pkg::spfs_power_t  power_ff,   nxt_power;
  logic [spfs_pkg::CNT_W-1:0] cnt_ff, nxt_cnt;
  logic                   core_reset_ff,  nxt_core_reset;
  logic                   clk_en_ff,      nxt_clk_en;
  logic                   pf_flag_ff,     nxt_pf_flag;
  logic                   vector_pf_ff,   nxt_vector_pf;
  logic                   resume_ff,      nxt_resume;
  logic                   woke_by_irq_ff, nxt_woke_by_irq;
  logic [15:0]            resume_addr_ff;

  // ==========================================================================
  // Counter end points
  // ==========================================================================
  localparam int unsigned   CW        = spfs_pkg::CNT_W;
  localparam logic [CW-1:0] CNT_ONE   = CW'(1);
  localparam logic [CW-1:0] WARM_LAST = CW'(WARMUP_CYCLES - 1);
  localparam logic [CW-1:0] POLL_LAST = CW'(POLL_CYCLES - 1);
  localparam logic [CW-1:0] ON_LAST   = CW'(spfs_pkg::POLL_ON_CYCLES - 1);
  localparam logic [CW-1:0] SET_LAST  = CW'(spfs_pkg::SETTLE_CYCLES - 1);

  // ==========================================================================
  // Next-state logic
  // ==========================================================================
  always_comb begin
    nxt_state       = state_ff;
    nxt_power       = power_ff;
    // Counter free-runs; every timed state clears it on entry
    nxt_cnt         = cnt_ff + CNT_ONE;
    nxt_core_reset  = core_reset_ff;
    nxt_clk_en      = clk_en_ff;
    nxt_pf_flag     = pf_flag_ff & ~pf_flag_clr;
    nxt_vector_pf   = 1'b0;
    nxt_resume      = 1'b0;
    nxt_woke_by_irq = woke_by_irq_ff;
    case (state_ff)
      spfs_pkg::ST_RUN: begin
        nxt_power = '{monitor_en: 1'b1, regulator_en: 1'b1, osc_en: 1'b1, sram_retain: 1'b1};
        if (stop_req) begin
          // Monitor off too: lowest stop current, drops go unseen
          nxt_state  = spfs_pkg::ST_STOP;
          nxt_power  = '{monitor_en: 1'b0, regulator_en: 1'b0, osc_en: 1'b0,
                         sram_retain: 1'b1};
          nxt_clk_en = 1'b0;
        end
      end
      spfs_pkg::ST_STOP: begin
        // Supply comparators are not looked at here
        if (wake_irq) begin
          nxt_state       = spfs_pkg::ST_SENSE;
          nxt_power.monitor_en = 1'b1;
          nxt_woke_by_irq = 1'b1;
          nxt_cnt         = '0;
        end
      end
      spfs_pkg::ST_SENSE: begin
        // Wait for monitor output to settle through the synchroniser
        if (cnt_ff >= SET_LAST) begin
          nxt_cnt = '0;
          if (sup.above_reset) begin
            if (!sup.above_warning) begin
              nxt_pf_flag = 1'b1;
            end
            nxt_state = spfs_pkg::ST_WARMUP;
            nxt_power = '{monitor_en: 1'b1, regulator_en: 1'b1, osc_en: 1'b1,
                          sram_retain: 1'b1};
          end else begin
            nxt_state      = spfs_pkg::ST_PFRST;
            nxt_core_reset = 1'b1;
            nxt_power      = '{monitor_en: 1'b0, regulator_en: 1'b0, osc_en: 1'b0,
                               sram_retain: 1'b1};
          end
        end
      end
      spfs_pkg::ST_WARMUP: begin
        if (cnt_ff >= WARM_LAST) begin
          nxt_state  = spfs_pkg::ST_RUN;
          nxt_clk_en = 1'b1;
          // Flag set: pick power-fail vector only if it outranks the wake source
          nxt_vector_pf   = pf_flag_ff & (pf_irq_prio_high | ~woke_by_irq_ff);
          nxt_woke_by_irq = 1'b0;
          if (core_reset_ff) begin
            nxt_core_reset = 1'b0;
            nxt_resume     = 1'b1;
          end
        end
      end
      spfs_pkg::ST_PFRST: begin
        // Duty-cycled monitor keeps leakage low while waiting
        nxt_power.monitor_en = (cnt_ff <= ON_LAST);
        if (cnt_ff >= POLL_LAST) begin
          nxt_cnt = '0;
        end
        // Trust the supply only once the monitor has settled in its on window
        if (power_ff.monitor_en && cnt_ff >= SET_LAST && cnt_ff <= ON_LAST
            && sup.above_reset) begin
          nxt_state = spfs_pkg::ST_RECOV;
          nxt_cnt   = '0;
          nxt_power = '{monitor_en: 1'b1, regulator_en: 1'b1, osc_en: 1'b1,
                        sram_retain: 1'b1};
        end
      end
      spfs_pkg::ST_RECOV: begin
        // One cycle for the supplies to come up before warm-up counts
        nxt_state = spfs_pkg::ST_WARMUP;
        nxt_cnt   = '0;
      end
      spfs_pkg::ST_POR: begin
        // Always leave through power-fail reset, never straight to run
        nxt_cnt = '0;
        if (sup.above_power_on) begin
          nxt_state = spfs_pkg::ST_PFRST;
        end
      end
      default: begin
        nxt_state = spfs_pkg::ST_POR;
      end
    endcase

    // Brown-out below power-on overrides state, power, reset, clock enable, flag and wake source, in every state
    if (!sup.above_power_on) begin
      nxt_state       = spfs_pkg::ST_POR;
      nxt_power       = '0;
      nxt_core_reset  = 1'b1;
      nxt_clk_en      = 1'b0;
      nxt_pf_flag     = 1'b0;
      nxt_woke_by_irq = 1'b0;
    end
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_ff       <= spfs_pkg::ST_POR;
      power_ff       <= '0;
      cnt_ff         <= '0;
      core_reset_ff  <= 1'b1;
      clk_en_ff      <= 1'b0;
      pf_flag_ff     <= 1'b0;
      vector_pf_ff   <= 1'b0;
      resume_ff      <= 1'b0;
      woke_by_irq_ff <= 1'b0;
      resume_addr_ff <= spfs_pkg::RESUME_ADDR;
    end else begin
      state_ff       <= nxt_state;
      power_ff       <= nxt_power;
      cnt_ff         <= nxt_cnt;
      core_reset_ff  <= nxt_core_reset;
      clk_en_ff      <= nxt_clk_en;
      pf_flag_ff     <= nxt_pf_flag;
      vector_pf_ff   <= nxt_vector_pf;
      resume_ff      <= nxt_resume;
      woke_by_irq_ff <= nxt_woke_by_irq;
      resume_addr_ff <= spfs_pkg::RESUME_ADDR;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign power        = power_ff;
  assign core_reset   = core_reset_ff;
  assign core_clk_en  = clk_en_ff;
  assign pf_flag      = pf_flag_ff;
  assign vector_pf    = vector_pf_ff;
  assign resume_valid = resume_ff;
  // Registered though constant, so every output leaves a flop
  assign resume_addr  = resume_addr_ff;
endmodule : spfs_sequencer
`default_nettype wire

// ==== rtl/spfs_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module spfs_sync #(
  parameter int unsigned W = 3
) (
  input  wire logic         ref_clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] nxt_s1;
  logic [W-1:0] nxt_s2;

  always_comb begin
    nxt_s1 = d;
    nxt_s2 = s1_ff;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s1_ff <= '0;
      s2_ff <= '0;
    end else begin
      s1_ff <= nxt_s1;
      s2_ff <= nxt_s2;
    end
  end

  assign q = s2_ff;
endmodule : spfs_sync
`default_nettype wire
